// [common/sync_timing_pkg.sv]
// shared constants for the synchronisation timing monitor
package sync_timing_pkg;
    // clock and time base
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned NS_PER_S = 1_000_000_000;
    localparam logic [31:0] CLK_NS = 32'(NS_PER_S / CLK_HZ);
    // register byte offsets
    localparam logic [7:0] IN_PARAM_COUNT_OFS = 8'h00;
    localparam logic [7:0] IN_SYNC_SELECT_OFS = 8'h04;
    localparam logic [7:0] IN_CYCLE_PERIOD_OFS = 8'h08;
    localparam logic [7:0] IN_SHIFT_TIME_OFS = 8'h0c;
    localparam logic [7:0] IN_SUPPORTED_MODES_OFS = 8'h10;
    localparam logic [7:0] IN_MIN_CYCLE_PERIOD_OFS = 8'h14;
    localparam logic [7:0] IN_CALC_COPY_TIME_OFS = 8'h18;
    localparam logic [7:0] IN_MEASURE_COMMAND_OFS = 8'h1c;
    localparam logic [7:0] IN_DELAY_TIME_OFS = 8'h20;
    localparam logic [7:0] OUT_SHIFT_TIME_OFS = 8'h24;
    localparam logic [7:0] OUT_CALC_COPY_TIME_OFS = 8'h28;
    localparam logic [7:0] OUT_MEASURE_COMMAND_OFS = 8'h2c;
    localparam logic [7:0] OUT_DELAY_TIME_OFS = 8'h30;
    localparam logic [7:0] OUT_MISSED_EVENT_COUNT_OFS = 8'h34;
    localparam logic [7:0] OUT_OVERRUN_COUNT_OFS = 8'h38;
    localparam logic [7:0] OUT_SHORT_GAP_COUNT_OFS = 8'h3c;
    localparam logic [7:0] OUT_LATE_FLAG_OFS = 8'h40;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h44;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h48;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h4c;
    // reset values
    localparam logic [7:0] IN_PARAM_COUNT_RST = 8'h20;
    localparam logic [15:0] IN_SYNC_SELECT_RST = 16'h0022;
    localparam logic [31:0] IN_CYCLE_PERIOD_RST = 32'h0007a120;
    localparam logic [31:0] IN_MIN_CYCLE_PERIOD_RST = 32'h00004e20;
    localparam logic [15:0] MEASURE_COMMAND_RST = 16'h0000;
    localparam logic [15:0] SUPPORTED_MODES_BASE = 16'hc007;
    // sync mode codes
    localparam logic [15:0] MODE_FREE_RUN = 16'h0000;
    localparam logic [15:0] MODE_SM3_EVENT = 16'h0001;
    localparam logic [15:0] MODE_SYNC0 = 16'h0002;
    localparam logic [15:0] MODE_SYNC1 = 16'h0003;
    localparam logic [15:0] MODE_SM2_EVENT = 16'h0022;
    // measurement command codes
    localparam logic [15:0] CMD_STOP = 16'h0000;
    localparam logic [15:0] CMD_START = 16'h0001;
    // supported-modes shift field
    localparam int unsigned SHIFT_FIELD_LSB = 4;
    localparam logic [1:0] SHIFT_LOCAL = 2'b01;
    localparam logic [1:0] SHIFT_SYNC1 = 2'b10;
    // interrupt status bit positions
    localparam int unsigned IRQ_MISSED_BIT = 0;
    localparam int unsigned IRQ_OVERRUN_BIT = 1;
    localparam int unsigned IRQ_SHORT_BIT = 2;
    localparam int unsigned IRQ_LATE_BIT = 3;
    localparam int unsigned IRQ_WIDTH = 4;
endpackage

// [hdl/max_interval_timer.sv]
// interval timer that keeps the largest interval seen
`timescale 1ns/1ps
module max_interval_timer #(
    parameter logic [31:0] RESET_VAL = 32'h00000000
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic enable,
    input wire logic clear,
    input wire logic start,
    input wire logic stop,
    // result in ns
    output logic [31:0] max_q
);
    logic running_q;
    logic [31:0] count_q;
    logic [31:0] elapsed;
    logic count_full;

    assign count_full = (count_q > (32'hffffffff - sync_timing_pkg::CLK_NS));
    assign elapsed = count_full ? 32'hffffffff
                                : count_q + sync_timing_pkg::CLK_NS;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            running_q <= 1'b0;
            count_q <= 32'h00000000;
        end
        else if (clear || !enable)
        begin
            running_q <= 1'b0;
            count_q <= 32'h00000000;
        end
        else if (start)
        begin
            running_q <= 1'b1;
            count_q <= 32'h00000000;
        end
        else if (stop)
        begin
            running_q <= 1'b0;
        end
        else if (running_q)
        begin
            count_q <= elapsed;
        end
    end

    // largest interval so far, zeroed by clear, not by start
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            max_q <= RESET_VAL;
        else if (clear)
            max_q <= 32'h00000000;
        else if (enable && running_q && stop && elapsed > max_q)
            max_q <= elapsed;
    end
endmodule

// [hdl/sync_timing_monitor.sv]
// synchronisation parameter and timing monitor with apb registers
//
// Overview of operation
// - command 0 stops, command 1 starts local cycle timing measurement.
// - while measuring, min cycle period and, in dc mode, the other timing entries keep the largest values measured.
// - starting a new measurement clears previously captured maxima.
// - operational and dc mode: missing sync-manager event bumps 16-bit count.
// - operational: late finish or early next cycle bumps 16-bit overrun count.
// - dc mode: too short sync0 to sync1 spacing bumps 16-bit count.
// - dc mode: flag set when last cycle drove outputs late, else cleared.
// - input sync mode codes 0,1,2,3,34; reset value 34.
// - supported modes word: bit0 free run, bit1 event, bits2-3 dc 01.
// - dc mode: bits 4-5 read 01 with outputs, 10 with sync1 shift, no outputs; 00 outside dc mode.
// - bit 14 set: timing entries are dynamic, filled by measurement.
// - input shift time: sync0 to input sampling, ns, 32-bit read-only.
// - input calc and copy time: sampling to availability for master, ns.
// - output calc and copy time: minimum sync0 to sync1 spacing, ns.
// - output delay time: sync1 to outputs driven, ns.
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module sync_timing_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // distributed clock pins
    input wire logic sync0_pin,
    input wire logic sync1_pin,
    // device state and events, same clock
    input wire logic operational,
    input wire logic outputs_present,
    input wire logic sm_event,
    input wire logic cycle_start,
    input wire logic cycle_done,
    input wire logic out_proc_done,
    input wire logic out_drive,
    input wire logic in_sample,
    input wire logic in_avail,
    input wire logic in_read,
    // interrupt
    output logic irq
);
    // pin synchronisers and edge detect
    logic sync0_meta_q, sync0_q, sync0_dly_q;
    logic sync1_meta_q, sync1_q, sync1_dly_q;
    logic sync0_rise, sync1_rise;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync0_meta_q <= 1'b0;
            sync0_q <= 1'b0;
            sync0_dly_q <= 1'b0;
            sync1_meta_q <= 1'b0;
            sync1_q <= 1'b0;
            sync1_dly_q <= 1'b0;
        end
        else
        begin
            sync0_meta_q <= sync0_pin;
            sync0_q <= sync0_meta_q;
            sync0_dly_q <= sync0_q;
            sync1_meta_q <= sync1_pin;
            sync1_q <= sync1_meta_q;
            sync1_dly_q <= sync1_q;
        end
    end

    assign sync0_rise = sync0_q && !sync0_dly_q;
    assign sync1_rise = sync1_q && !sync1_dly_q;

    // apb decode
    logic setup_phase, wr_access;
    logic [7:0] addr_word;
    logic [31:0] wmask;
    logic wr_sync_select, wr_cycle_period, wr_in_cmd, wr_out_cmd;
    logic wr_irq_clear, wr_irq_enable;

    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign addr_word = {paddr[7:2], 2'b00};
    assign wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                    {8{pstrb[0]}}};
    assign wr_sync_select = wr_access
        && addr_word == sync_timing_pkg::IN_SYNC_SELECT_OFS;
    assign wr_cycle_period = wr_access
        && addr_word == sync_timing_pkg::IN_CYCLE_PERIOD_OFS;
    assign wr_in_cmd = wr_access
        && addr_word == sync_timing_pkg::IN_MEASURE_COMMAND_OFS;
    assign wr_out_cmd = wr_access
        && addr_word == sync_timing_pkg::OUT_MEASURE_COMMAND_OFS;
    assign wr_irq_clear = wr_access
        && addr_word == sync_timing_pkg::IRQ_CLEAR_OFS;
    assign wr_irq_enable = wr_access
        && addr_word == sync_timing_pkg::IRQ_ENABLE_OFS;

    // software registers
    logic [15:0] in_sync_select_q;
    logic [31:0] in_cycle_period_q;
    logic [15:0] in_measure_command_q, out_measure_command_q;
    logic [3:0] irq_enable_q;
    logic [15:0] sel_new, in_cmd_new, out_cmd_new;
    logic sel_legal;

    assign sel_new = (in_sync_select_q & ~wmask[15:0])
                   | (pwdata[15:0] & wmask[15:0]);
    assign in_cmd_new = (in_measure_command_q & ~wmask[15:0])
                      | (pwdata[15:0] & wmask[15:0]);
    assign out_cmd_new = (out_measure_command_q & ~wmask[15:0])
                       | (pwdata[15:0] & wmask[15:0]);
    // only documented mode codes are accepted
    assign sel_legal = sel_new == sync_timing_pkg::MODE_FREE_RUN
        || sel_new == sync_timing_pkg::MODE_SM3_EVENT
        || sel_new == sync_timing_pkg::MODE_SYNC0
        || sel_new == sync_timing_pkg::MODE_SYNC1
        || sel_new == sync_timing_pkg::MODE_SM2_EVENT;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            in_sync_select_q <= sync_timing_pkg::IN_SYNC_SELECT_RST;
            in_cycle_period_q <= sync_timing_pkg::IN_CYCLE_PERIOD_RST;
            in_measure_command_q <= sync_timing_pkg::MEASURE_COMMAND_RST;
            out_measure_command_q <= sync_timing_pkg::MEASURE_COMMAND_RST;
            irq_enable_q <= 4'h0;
        end
        else
        begin
            if (wr_sync_select && sel_legal)
                in_sync_select_q <= sel_new;
            if (wr_cycle_period)
                in_cycle_period_q <= (in_cycle_period_q & ~wmask)
                                   | (pwdata & wmask);
            if (wr_in_cmd)
                in_measure_command_q <= in_cmd_new;
            if (wr_out_cmd)
                out_measure_command_q <= out_cmd_new;
            if (wr_irq_enable && pstrb[0])
                irq_enable_q <= pwdata[3:0];
        end
    end

    // measurement control
    logic measuring, measuring_q, meas_clear, dc_mode;

    assign measuring =
        in_measure_command_q == sync_timing_pkg::CMD_START
        || out_measure_command_q == sync_timing_pkg::CMD_START;
    assign meas_clear = measuring && !measuring_q;
    assign dc_mode = in_sync_select_q == sync_timing_pkg::MODE_SYNC0
        || in_sync_select_q == sync_timing_pkg::MODE_SYNC1;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            measuring_q <= 1'b0;
        else
            measuring_q <= measuring;
    end

    // timing measurements, largest value kept
    logic [31:0] in_shift_time, in_calc_copy_time, in_delay_time;
    logic [31:0] in_min_cycle_period;
    logic [31:0] out_shift_time, out_calc_copy_time, out_delay_time;
    logic dc_meas;

    assign dc_meas = measuring && dc_mode;

    max_interval_timer u_in_shift (
        .clk(clk), .rstn(rstn), .enable(dc_meas), .clear(meas_clear),
        .start(sync0_rise), .stop(in_sample), .max_q(in_shift_time)
    );
    max_interval_timer u_in_calc (
        .clk(clk), .rstn(rstn), .enable(dc_meas), .clear(meas_clear),
        .start(in_sample), .stop(in_avail), .max_q(in_calc_copy_time)
    );
    max_interval_timer u_in_delay (
        .clk(clk), .rstn(rstn), .enable(dc_meas), .clear(meas_clear),
        .start(sync1_rise), .stop(in_read), .max_q(in_delay_time)
    );
    max_interval_timer #(
        .RESET_VAL(sync_timing_pkg::IN_MIN_CYCLE_PERIOD_RST)
    ) u_min_cycle (
        .clk(clk), .rstn(rstn), .enable(measuring), .clear(meas_clear),
        .start(cycle_start), .stop(cycle_done),
        .max_q(in_min_cycle_period)
    );
    max_interval_timer u_out_shift (
        .clk(clk), .rstn(rstn), .enable(dc_meas), .clear(meas_clear),
        .start(sync0_rise), .stop(out_drive), .max_q(out_shift_time)
    );
    max_interval_timer u_out_calc (
        .clk(clk), .rstn(rstn), .enable(dc_meas), .clear(meas_clear),
        .start(sync0_rise), .stop(out_proc_done),
        .max_q(out_calc_copy_time)
    );
    max_interval_timer u_out_delay (
        .clk(clk), .rstn(rstn), .enable(dc_meas), .clear(meas_clear),
        .start(sync1_rise), .stop(out_drive), .max_q(out_delay_time)
    );

    // cycle tracking for the error counters
    logic seen_sm_q, busy_q, proc_done_q, driven_q, late_q;
    logic missed_evt, overrun_evt, short_evt, late_evt;

    assign missed_evt = operational && dc_mode && sync0_rise
                      && !seen_sm_q && !sm_event;
    assign overrun_evt = operational && cycle_start && busy_q
                       && !cycle_done;
    assign short_evt = dc_mode && sync1_rise && !proc_done_q
                     && !out_proc_done;
    assign late_evt = dc_mode && sync0_rise && !driven_q && !out_drive;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            seen_sm_q <= 1'b1;
            busy_q <= 1'b0;
            proc_done_q <= 1'b1;
            driven_q <= 1'b1;
            late_q <= 1'b0;
        end
        else
        begin
            seen_sm_q <= sync0_rise ? 1'b0 : (seen_sm_q || sm_event);
            busy_q <= cycle_start ? 1'b1 : (busy_q && !cycle_done);
            proc_done_q <= sync0_rise ? 1'b0 : (proc_done_q || out_proc_done);
            driven_q <= sync0_rise ? 1'b0 : (driven_q || out_drive);
            if (!dc_mode)
                late_q <= 1'b0;
            else if (sync0_rise)
                late_q <= late_evt;
        end
    end

    // saturating event counters
    logic [15:0] missed_count_q, overrun_count_q, short_count_q;

    function automatic logic [15:0] sat_inc(input logic [15:0] v);
        sat_inc = (v == 16'hffff) ? v : v + 16'h0001;
    endfunction

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            missed_count_q <= 16'h0000;
            overrun_count_q <= 16'h0000;
            short_count_q <= 16'h0000;
        end
        else
        begin
            if (missed_evt)
                missed_count_q <= sat_inc(missed_count_q);
            if (overrun_evt)
                overrun_count_q <= sat_inc(overrun_count_q);
            if (short_evt)
                short_count_q <= sat_inc(short_count_q);
        end
    end

    // interrupt status, set wins over clear
    logic [3:0] irq_status_q, irq_set, irq_clr;

    assign irq_set = {late_evt, short_evt, overrun_evt, missed_evt};
    assign irq_clr = (wr_irq_clear && pstrb[0]) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_status_q <= 4'h0;
        else
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
    end

    assign irq = |(irq_status_q & irq_enable_q);

    // supported modes word
    logic [15:0] supported_modes;
    logic [1:0] shift_field;

    assign shift_field = !dc_mode ? 2'b00
        : (outputs_present ? sync_timing_pkg::SHIFT_LOCAL
                           : sync_timing_pkg::SHIFT_SYNC1);
    // base carries free run, event, dc 01 and dynamic times bits
    assign supported_modes = sync_timing_pkg::SUPPORTED_MODES_BASE
        | {10'h000, shift_field, 4'h0};

    // read mux
    logic [31:0] rdata;
    logic addr_hit;

    always_comb
    begin
        rdata = 32'h00000000;
        addr_hit = 1'b1;
        unique case (addr_word)
            sync_timing_pkg::IN_PARAM_COUNT_OFS:
                rdata = {24'h000000, sync_timing_pkg::IN_PARAM_COUNT_RST};
            sync_timing_pkg::IN_SYNC_SELECT_OFS:
                rdata = {16'h0000, in_sync_select_q};
            sync_timing_pkg::IN_CYCLE_PERIOD_OFS:
                rdata = in_cycle_period_q;
            sync_timing_pkg::IN_SHIFT_TIME_OFS:
                rdata = in_shift_time;
            sync_timing_pkg::IN_SUPPORTED_MODES_OFS:
                rdata = {16'h0000, supported_modes};
            sync_timing_pkg::IN_MIN_CYCLE_PERIOD_OFS:
                rdata = in_min_cycle_period;
            sync_timing_pkg::IN_CALC_COPY_TIME_OFS:
                rdata = in_calc_copy_time;
            sync_timing_pkg::IN_MEASURE_COMMAND_OFS:
                rdata = {16'h0000, in_measure_command_q};
            sync_timing_pkg::IN_DELAY_TIME_OFS:
                rdata = in_delay_time;
            sync_timing_pkg::OUT_SHIFT_TIME_OFS:
                rdata = out_shift_time;
            sync_timing_pkg::OUT_CALC_COPY_TIME_OFS:
                rdata = out_calc_copy_time;
            sync_timing_pkg::OUT_MEASURE_COMMAND_OFS:
                rdata = {16'h0000, out_measure_command_q};
            sync_timing_pkg::OUT_DELAY_TIME_OFS:
                rdata = out_delay_time;
            sync_timing_pkg::OUT_MISSED_EVENT_COUNT_OFS:
                rdata = {16'h0000, missed_count_q};
            sync_timing_pkg::OUT_OVERRUN_COUNT_OFS:
                rdata = {16'h0000, overrun_count_q};
            sync_timing_pkg::OUT_SHORT_GAP_COUNT_OFS:
                rdata = {16'h0000, short_count_q};
            sync_timing_pkg::OUT_LATE_FLAG_OFS:
                rdata = {31'h00000000, late_q};
            sync_timing_pkg::IRQ_STATUS_OFS:
                rdata = {28'h0000000, irq_status_q};
            sync_timing_pkg::IRQ_CLEAR_OFS:
                rdata = 32'h00000000;
            sync_timing_pkg::IRQ_ENABLE_OFS:
                rdata = {28'h0000000, irq_enable_q};
            default:
                addr_hit = 1'b0;
        endcase
    end

    // read data and error registered in the setup cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (setup_phase)
        begin
            prdata <= pwrite ? 32'h00000000 : rdata;
            pslverr <= !addr_hit;
        end
    end

    assign pready = 1'b1;
endmodule

// [testbench/sync_timing_monitor_checker.sv]
// port assertions for the timing monitor
`timescale 1ns/1ps
module sync_timing_monitor_checker (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    // interrupt
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic [15:0] ovr_q;
    logic [15:0] cmd_q;
    wire logic rd_set = psel && !penable && !pwrite;
    wire logic acc = psel && penable;
    // last overrun count read and last command written
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ovr_q <= 16'h0000;
            cmd_q <= 16'h0000;
        end
        else
        begin
            if (acc && !pwrite && paddr == 8'h38)
                ovr_q <= prdata[15:0];
            if (acc && pwrite && paddr == 8'h1c)
                cmd_q <= pwdata[15:0];
        end
    end
    chk_cmd_readback: assert property (rd_set && paddr == 8'h1c
        |=> prdata == {16'h0000, cmd_q}) else $error("command readback");
    chk_count_width: assert property (
        rd_set && paddr inside {8'h34, 8'h38, 8'h3c}
        |=> prdata[31:16] == 16'h0000) else $error("counter too wide");
    chk_late_bit: assert property (rd_set && paddr == 8'h40
        |=> prdata[31:1] == 31'h0) else $error("late flag too wide");
    chk_select_legal: assert property (rd_set && paddr == 8'h04
        |=> prdata inside {32'h0, 32'h1, 32'h2, 32'h3, 32'h22})
        else $error("illegal sync mode");
    chk_modes_fixed: assert property (rd_set && paddr == 8'h10
        |=> prdata[31:6] == 26'h300 && prdata[3:0] == 4'h7)
        else $error("supported modes fixed bits");
    chk_modes_shift: assert property (rd_set && paddr == 8'h10
        |=> prdata[5:4] != 2'b11) else $error("shift field");
    chk_overrun_mono: assert property (
        acc && !pwrite && paddr == 8'h38 |-> prdata[15:0] >= ovr_q)
        else $error("overrun count went down");
    chk_irq_fall: assert property ($fell(irq)
        |-> $past(acc && pwrite && (paddr == 8'h48 || paddr == 8'h4c)))
        else $error("irq fell without clear or mask");
endmodule
bind sync_timing_monitor sync_timing_monitor_checker u_chk (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .irq(irq)
);

// [testbench/dc_sync_source.sv]
// distributed clock source driving the sync pins
`timescale 1ns/1ps
module dc_sync_source (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // one frame per trigger, sync1 after gap cycles
    input wire logic trig,
    input wire logic [7:0] gap,
    // pins
    output logic sync0_pin,
    output logic sync1_pin
);
    logic [8:0] cnt_q;
    logic busy_q;
    wire logic [8:0] g = {1'b0, gap};
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_q <= 9'h000;
            busy_q <= 1'b0;
        end
        else if (trig)
        begin
            cnt_q <= 9'h000;
            busy_q <= 1'b1;
        end
        else if (busy_q)
        begin
            cnt_q <= cnt_q + 9'h001;
            busy_q <= cnt_q < g + 9'h004;
        end
    end
    // pins low between frames
    assign sync0_pin = busy_q && cnt_q < 9'h003;
    assign sync1_pin = busy_q && cnt_q >= g && cnt_q < g + 9'h003;
endmodule

// [testbench/sync_timing_monitor_bench.sv]
// self-checking bench for the timing monitor
`timescale 1ns/1ps
`define CHECK(nm, e, g) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            bad_count++; \
            $display("[ERR] %s exp %h got %h", nm, e, g); \
        end \
    end
module sync_timing_monitor_bench;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic s0;
    logic s1;
    logic trig = 1'b0;
    logic op = 1'b0;
    logic outp = 1'b1;
    logic [7:0] ev = 8'h00;
    logic [32:0] exp_q[$];
    logic [31:0] rs = 32'd28324;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [31:0] rst_v[20] = '{32'h20, 32'h22, 32'h7a120, 0, 32'hc007,
        32'h4e20, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0};
    logic [31:0] modes[5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h22};
    always #10 clk = ~clk;
    dc_sync_source u_src (.clk(clk), .rstn(rstn), .trig(trig),
        .gap(8'd20), .sync0_pin(s0), .sync1_pin(s1));
    sync_timing_monitor dut (.clk(clk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sync0_pin(s0), .sync1_pin(s1),
        .operational(op), .outputs_present(outp), .sm_event(ev[0]),
        .cycle_start(ev[1]), .cycle_done(ev[2]), .out_proc_done(ev[3]),
        .out_drive(ev[4]), .in_sample(ev[5]), .in_avail(ev[6]),
        .in_read(ev[7]), .irq(irq));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1)
            @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic span(input int a, input int b, input int n);
        ev[a] <= 1'b1;
        @(posedge clk);
        ev[a] <= 1'b0;
        repeat (n - 1) @(posedge clk);
        ev[b] <= 1'b1;
        @(posedge clk);
        ev[b] <= 1'b0;
        @(posedge clk);
    endtask
    task automatic fire(input logic pr, input logic dr, input logic sm);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        repeat (10) @(posedge clk);
        ev[3] <= pr;
        ev[4] <= dr;
        ev[0] <= sm;
        ev[5] <= dr;
        @(posedge clk);
        ev[3] <= 1'b0;
        ev[5] <= 1'b0;
        ev[4] <= 1'b0;
        ev[0] <= 1'b0;
        repeat (25) @(posedge clk);
    endtask
    task automatic chk_irq(input logic e);
        @(negedge clk);
        `CHECK("irq", e, irq)
        @(posedge clk);
    endtask
    // read results popped in order
    always @(posedge clk)
    begin
        logic [32:0] e;
        if (psel && penable && pready && !pwrite)
        begin
            e = exp_q.pop_front();
            `CHECK("read", e, {pslverr, prdata})
        end
    end
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            bad_count++;
            finish_test;
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 20; i++)
            rd(8'(i * 4), {1'b0, rst_v[i]});
        rd(8'h50, {1'b1, 32'h0});
        apb(1'b1, 8'h00, 32'h55);
        rd(8'h00, {1'b0, 32'h20});
        for (int i = 0; i < 3; i++)
        begin
            rs = xs(rs);
            apb(1'b1, 8'h08, 32'h4e20 + {16'h0, rs[15:0]});
            rd(8'h08, {1'b0, 32'h4e20 + {16'h0, rs[15:0]}});
        end
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, 8'h04, modes[i]);
            rd(8'h04, {1'b0, modes[i]});
        end
        apb(1'b1, 8'h04, 32'h5);
        rd(8'h04, {1'b0, 32'h22});
        apb(1'b1, 8'h04, 32'h2);
        rd(8'h10, {1'b0, 32'hc017});
        outp <= 1'b0;
        rd(8'h10, {1'b0, 32'hc027});
        outp <= 1'b1;
        apb(1'b1, 8'h1c, 32'h1);
        rd(8'h1c, {1'b0, 32'h1});
        rd(8'h14, {1'b0, 32'h0});
        span(1, 2, 5);
        rd(8'h14, {1'b0, 32'd100});
        span(1, 2, 3);
        span(5, 6, 7);
        rd(8'h14, {1'b0, 32'd100});
        rd(8'h18, {1'b0, 32'd140});
        apb(1'b1, 8'h1c, 32'h0);
        span(1, 2, 9);
        rd(8'h14, {1'b0, 32'd100});
        apb(1'b1, 8'h1c, 32'h1);
        rd(8'h18, {1'b0, 32'h0});
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        apb(1'b1, 8'h04, 32'h2);
        op <= 1'b1;
        fire(1, 0, 0);
        fire(0, 1, 1);
        fire(0, 0, 0);
        fire(1, 1, 1);
        rd(8'h34, {1'b0, 32'h2});
        rd(8'h3c, {1'b0, 32'h2});
        rd(8'h40, {1'b0, 32'h1});
        fire(1, 1, 1);
        rd(8'h40, {1'b0, 32'h0});
        rd(8'h34, {1'b0, 32'h2});
        apb(1'b1, 8'h2c, 32'h1);
        rd(8'h2c, {1'b0, 32'h1});
        fire(1, 1, 1);
        fire(1, 1, 1);
        rd(8'h0c, {1'b0, 32'ha0});
        rd(8'h24, {1'b0, 32'ha0});
        rd(8'h28, {1'b0, 32'ha0});
        rd(8'h30, {1'b0, 32'h1f4});
        span(1, 2, 2);
        span(1, 1, 3);
        rd(8'h38, {1'b0, 32'h1});
        ev[1] <= 1'b1;
        repeat (65540) @(posedge clk);
        ev[1] <= 1'b0;
        rd(8'h38, {1'b0, 32'hffff});
        rd(8'h44, {1'b0, 32'hf});
        chk_irq(1'b0);
        apb(1'b1, 8'h4c, 32'h2);
        chk_irq(1'b1);
        apb(1'b1, 8'h48, 32'h2);
        chk_irq(1'b0);
        span(1, 1, 3);
        chk_irq(1'b1);
        apb(1'b1, 8'h4c, 32'h0);
        chk_irq(1'b0);
        rd(8'h48, {1'b0, 32'h0});
        repeat (3) @(posedge clk);
        finish_test;
    end
endmodule
